// *** include/sync_pll_pkg.sv ***
// Constants for the sync processing and pixel clock PLL control block.
package sync_pll_pkg;
  // Clock and separator timebase.
  localparam int CLK_HZ = 100_000_000;
  localparam int SEP_CLK_HZ = 5_000_000;
  localparam int TICK_CYCLES = CLK_HZ / SEP_CLK_HZ;
  localparam int TICK_W = 5;
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);
  // Activity and polarity window, in microseconds and in timebase ticks.
  localparam int ACT_TIMEOUT_US = 20_000;
  localparam int ACT_TIMEOUT_TICKS = ACT_TIMEOUT_US * (SEP_CLK_HZ / 1_000_000);
  localparam int WIN_W = 17;
  // Register bus.
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam logic [ADDR_W-1:0] ADDR_DIV_HIGH = 8'h01;
  localparam logic [ADDR_W-1:0] ADDR_DIV_LOW = 8'h02;
  localparam logic [ADDR_W-1:0] ADDR_VCO_PUMP = 8'h03;
  localparam logic [ADDR_W-1:0] ADDR_SRC_CTRL = 8'h0e;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h14;
  localparam logic [ADDR_W-1:0] ADDR_SEP_CTRL = 8'h16;
  localparam logic [ADDR_W-1:0] ADDR_SEP_TICKS = 8'h17;
  // Field positions.
  localparam int SRC_LINE_OVR = 4;
  localparam int SRC_LINE_VAL = 3;
  localparam int SRC_FRAME_OVR = 1;
  localparam int SRC_FRAME_VAL = 0;
  localparam int STAT_LINE_ACT = 7;
  localparam int STAT_LINE_POL = 5;
  localparam int STAT_FRAME_ACT = 4;
  localparam int STAT_FRAME_POL = 2;
  localparam int STAT_GREEN_ACT = 1;
  localparam int VCO_LSB = 6;
  localparam int PUMP_LSB = 3;
  localparam int SEP_COMP_SEL = 0;
  localparam int SEP_COAST_SEL = 1;
  // Divider: high register holds bits 11:4, low register bits 7:4 hold 3:0.
  localparam int DIV_W = 12;
  localparam logic [DIV_W-1:0] DIV_RESET = 12'h69d;
  localparam logic [DIV_W-1:0] DIV_MIN_SETTING = 12'h010;
  // Reset values.
  localparam logic [DATA_W-1:0] VCO_PUMP_RESET = 8'h00;
  localparam logic [DATA_W-1:0] SRC_CTRL_RESET = 8'h00;
  localparam logic [DATA_W-1:0] SEP_CTRL_RESET = 8'h00;
  localparam logic [DATA_W-1:0] SEP_TICKS_RESET = 8'h20;
  // Detector indices.
  typedef enum logic [1:0] {
    DET_LINE = 2'b00,
    DET_GREEN = 2'b01,
    DET_FRAME_IN = 2'b10,
    DET_FRAME_OUT = 2'b11
  } det_type;
endpackage

// *** src/sync_pll_ctrl.sv ***
// Sync activity, polarity, source selection, separator and PLL controls.
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ps
module sync_pll_ctrl #(
  parameter int ACT_TIMEOUT_TICKS = sync_pll_pkg::ACT_TIMEOUT_TICKS
) (
  // Clock and reset.
  input wire logic i_clock,
  input wire logic i_rst_n,
  // Register port.
  input wire logic [sync_pll_pkg::ADDR_W-1:0] i_addr,
  input wire logic [sync_pll_pkg::DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [sync_pll_pkg::DATA_W-1:0] o_rdata,
  // Sync pins.
  input wire logic i_line_sync,
  input wire logic i_frame_sync,
  input wire logic i_green_embedded_sync_in,
  // Sync outputs.
  output logic o_pll_ref,
  output logic o_line_ref_auto_select,
  output logic o_frame_src_auto_select,
  output logic o_frame_sync_out,
  output logic o_coast_sync,
  // PLL controls.
  output logic o_pll_feedback,
  output logic [1:0] o_vco_range,
  output logic [2:0] o_pump_current
);
  localparam int WW = sync_pll_pkg::WIN_W;
  localparam logic [WW-1:0] WIN_LAST = WW'(ACT_TIMEOUT_TICKS - 1);
  localparam logic [WW-1:0] WIN_HALF = WW'(ACT_TIMEOUT_TICKS / 2);
  localparam int DW = sync_pll_pkg::DIV_W;

  logic [DW-1:0] div_setting_q;
  logic [7:0] vco_pump_q;
  logic [7:0] src_ctrl_q;
  logic [7:0] sep_ctrl_q;
  logic [7:0] sep_ticks_q;
  logic [7:0] rdata_q;
  logic [2:0] pin_meta_q;
  logic [2:0] pin_sync_q;
  logic [sync_pll_pkg::TICK_W-1:0] tick_cnt_q;
  logic tick;
  logic [WW-1:0] win_cnt_q;
  logic win_end;
  logic [3:0] sig;
  logic [3:0] prev_q;
  logic [3:0] settle_q;
  logic [3:0] edge_now;
  logic [3:0] edge_seen_q;
  logic [3:0] active_q;
  logic [3:0] pol_q;
  logic [WW-1:0] high_cnt_q [4];
  logic line_sel_q;
  logic line_sel_d;
  logic frame_sel_q;
  logic frame_sel_d;
  logic pll_ref_q;
  logic comp_in;
  logic sep_out_q;
  logic [7:0] loop_filter_node_cnt_q;
  logic frame_out_q;
  logic coast_q;
  logic [DW-1:0] div_cnt_q;
  logic [DW-1:0] eff_div;
  logic feedback_q;
  logic [7:0] status;

  // Effective divider setting, clamped so the ratio never drops below 17.
  function automatic logic [DW-1:0] clamp_div(input logic [DW-1:0] s);
    clamp_div = (s < sync_pll_pkg::DIV_MIN_SETTING) ?
                sync_pll_pkg::DIV_MIN_SETTING : s;
  endfunction

  assign eff_div = clamp_div(div_setting_q);

  // Register writes.
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      div_setting_q <= sync_pll_pkg::DIV_RESET;
      vco_pump_q <= sync_pll_pkg::VCO_PUMP_RESET;
      src_ctrl_q <= sync_pll_pkg::SRC_CTRL_RESET;
      sep_ctrl_q <= sync_pll_pkg::SEP_CTRL_RESET;
      sep_ticks_q <= sync_pll_pkg::SEP_TICKS_RESET;
    end else if (i_wr) begin
      case (i_addr)
        sync_pll_pkg::ADDR_DIV_HIGH: begin
          div_setting_q[DW-1:4] <= i_wdata;
        end
        sync_pll_pkg::ADDR_DIV_LOW: begin
          div_setting_q[3:0] <= i_wdata[7:4];
        end
        sync_pll_pkg::ADDR_VCO_PUMP: begin
          vco_pump_q <= i_wdata;
        end
        sync_pll_pkg::ADDR_SRC_CTRL: begin
          src_ctrl_q <= i_wdata;
        end
        sync_pll_pkg::ADDR_SEP_CTRL: begin
          sep_ctrl_q <= i_wdata;
        end
        sync_pll_pkg::ADDR_SEP_TICKS: begin
          sep_ticks_q <= i_wdata;
        end
        default: begin
        end
      endcase
    end
  end

  always_comb begin
    status = 8'h00;
    status[sync_pll_pkg::STAT_LINE_ACT] = active_q[sync_pll_pkg::DET_LINE];
    status[sync_pll_pkg::STAT_LINE_POL] = pol_q[sync_pll_pkg::DET_LINE];
    status[sync_pll_pkg::STAT_FRAME_ACT] =
      active_q[sync_pll_pkg::DET_FRAME_IN];
    status[sync_pll_pkg::STAT_FRAME_POL] = pol_q[sync_pll_pkg::DET_FRAME_OUT];
    status[sync_pll_pkg::STAT_GREEN_ACT] = active_q[sync_pll_pkg::DET_GREEN];
  end

  // Read data stands in the cycle after the strobe; unmapped reads give 0.
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      rdata_q <= 8'h00;
    end else if (i_rd) begin
      case (i_addr)
        sync_pll_pkg::ADDR_DIV_HIGH: rdata_q <= div_setting_q[DW-1:4];
        sync_pll_pkg::ADDR_DIV_LOW: rdata_q <= {div_setting_q[3:0], 4'h0};
        sync_pll_pkg::ADDR_VCO_PUMP: rdata_q <= vco_pump_q;
        sync_pll_pkg::ADDR_SRC_CTRL: rdata_q <= src_ctrl_q;
        sync_pll_pkg::ADDR_STATUS: rdata_q <= status;
        sync_pll_pkg::ADDR_SEP_CTRL: rdata_q <= sep_ctrl_q;
        sync_pll_pkg::ADDR_SEP_TICKS: rdata_q <= sep_ticks_q;
        default: rdata_q <= 8'h00;
      endcase
    end else begin
      rdata_q <= 8'h00;
    end
  end

  // Two-stage synchronisers for {frame, green, line}.
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      pin_meta_q <= 3'h0;
      pin_sync_q <= 3'h0;
      settle_q <= 4'h0;
    end else begin
      pin_meta_q <= {i_frame_sync, i_green_embedded_sync_in, i_line_sync};
      pin_sync_q <= pin_meta_q;
      settle_q <= {settle_q[2:0], 1'b1};
    end
  end

  // Separator timebase of nominally 5 MHz, divided down from i_clock.
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      tick_cnt_q <= '0;
    end else if (tick) begin
      tick_cnt_q <= '0;
    end else begin
      tick_cnt_q <= tick_cnt_q + (sync_pll_pkg::TICK_W)'(1);
    end
  end
  assign tick = (tick_cnt_q == sync_pll_pkg::TICK_LAST);

  // Shared detector window in timebase ticks.
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      win_cnt_q <= '0;
    end else if (win_end) begin
      win_cnt_q <= '0;
    end else if (tick) begin
      win_cnt_q <= win_cnt_q + WW'(1);
    end
  end
  assign win_end = tick && (win_cnt_q == WIN_LAST);

  assign sig = {frame_out_q, pin_sync_q};

  // Activity: any edge in the window. Polarity: high under half the window.
  // Edges count only once real pin samples fill the pipe, so a pin that
  // idles high shows no false edge after reset.
  assign edge_now = (sig ^ prev_q) & {4{settle_q[3]}};
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      prev_q <= '0;
      edge_seen_q <= '0;
      high_cnt_q <= '{default: '0};
      active_q <= '0;
      pol_q <= '0;
    end else begin
      prev_q <= sig;
      if (win_end) begin
        edge_seen_q <= '0;
        active_q <= edge_seen_q | edge_now;
      end else begin
        edge_seen_q <= edge_seen_q | edge_now;
      end
      for (int i = 0; i < 4; i++) begin
        if (win_end) begin
          high_cnt_q[i] <= '0;
          pol_q[i] <= (high_cnt_q[i] < WIN_HALF);
        end else if (tick) begin
          high_cnt_q[i] <= high_cnt_q[i] + WW'(sig[i]);
        end
      end
    end
  end

  // Source selection: 1 picks green sync / separator respectively.
  always_comb begin
    if (src_ctrl_q[sync_pll_pkg::SRC_LINE_OVR]) begin
      line_sel_d = src_ctrl_q[sync_pll_pkg::SRC_LINE_VAL];
    end else if (active_q[sync_pll_pkg::DET_LINE]) begin
      line_sel_d = active_q[sync_pll_pkg::DET_GREEN] &
                   src_ctrl_q[sync_pll_pkg::SRC_LINE_VAL];
    end else begin
      line_sel_d = active_q[sync_pll_pkg::DET_GREEN];
    end
    if (src_ctrl_q[sync_pll_pkg::SRC_FRAME_OVR]) begin
      frame_sel_d = src_ctrl_q[sync_pll_pkg::SRC_FRAME_VAL];
    end else if (active_q[sync_pll_pkg::DET_FRAME_IN]) begin
      frame_sel_d = 1'b0;
    end else if (active_q[sync_pll_pkg::DET_GREEN]) begin
      frame_sel_d = 1'b1;
    end else begin
      frame_sel_d = src_ctrl_q[sync_pll_pkg::SRC_FRAME_VAL];
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      line_sel_q <= 1'b0;
      frame_sel_q <= 1'b0;
    end else begin
      line_sel_q <= line_sel_d;
      frame_sel_q <= frame_sel_d;
    end
  end

  // Reference is turned to active high whatever the source polarity.
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      pll_ref_q <= 1'b0;
    end else if (line_sel_q) begin
      pll_ref_q <= pin_sync_q[sync_pll_pkg::DET_GREEN] ^
                   ~pol_q[sync_pll_pkg::DET_GREEN];
    end else begin
      pll_ref_q <= pin_sync_q[sync_pll_pkg::DET_LINE] ^
                   ~pol_q[sync_pll_pkg::DET_LINE];
    end
  end

  assign comp_in = sep_ctrl_q[sync_pll_pkg::SEP_COMP_SEL] ?
                   pin_sync_q[sync_pll_pkg::DET_GREEN] :
                   pin_sync_q[sync_pll_pkg::DET_LINE];

  // Low-pass separator: output follows only a level held past the count.
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      sep_out_q <= 1'b0;
      loop_filter_node_cnt_q <= 8'h00;
    end else if (tick) begin
      if (comp_in == sep_out_q) begin
        loop_filter_node_cnt_q <= 8'h00;
      end else if (loop_filter_node_cnt_q >= sep_ticks_q) begin
        sep_out_q <= comp_in;
        loop_filter_node_cnt_q <= 8'h00;
      end else begin
        loop_filter_node_cnt_q <= loop_filter_node_cnt_q + 8'h01;
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      frame_out_q <= 1'b0;
      coast_q <= 1'b0;
    end else begin
      frame_out_q <= frame_sel_q ? sep_out_q :
                     pin_sync_q[sync_pll_pkg::DET_FRAME_IN];
      coast_q <= sep_ctrl_q[sync_pll_pkg::SEP_COAST_SEL] ? sep_out_q :
                 pin_sync_q[sync_pll_pkg::DET_FRAME_IN];
    end
  end

  // Feedback divider: one pulse per line of setting plus one pixel clocks.
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      div_cnt_q <= '0;
      feedback_q <= 1'b0;
    end else if (div_cnt_q >= eff_div) begin
      div_cnt_q <= '0;
      feedback_q <= 1'b1;
    end else begin
      div_cnt_q <= div_cnt_q + DW'(1);
      feedback_q <= 1'b0;
    end
  end

  assign o_rdata = rdata_q;
  assign o_pll_ref = pll_ref_q;
  assign o_line_ref_auto_select = line_sel_q;
  assign o_frame_src_auto_select = frame_sel_q;
  assign o_frame_sync_out = frame_out_q;
  assign o_coast_sync = coast_q;
  assign o_pll_feedback = feedback_q;
  assign o_vco_range = vco_pump_q[sync_pll_pkg::VCO_LSB +: 2];
  assign o_pump_current =
    vco_pump_q[sync_pll_pkg::PUMP_LSB +: 3];

  // Helpers for the checks: cycles since the last feedback pulse.
  logic [DW:0] gap_q;
  logic div_changed_q;
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      gap_q <= '0;
      div_changed_q <= 1'b1;
    end else begin
      gap_q <= feedback_q ? '0 : gap_q + (DW+1)'(1);
      div_changed_q <= (i_wr && (i_addr == sync_pll_pkg::ADDR_DIV_HIGH ||
                        i_addr == sync_pll_pkg::ADDR_DIV_LOW)) ||
                       (div_changed_q && !feedback_q);
    end
  end

  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_rst_n);

  a_status_read: assert property (
    i_rd && i_addr == sync_pll_pkg::ADDR_STATUS |=> o_rdata == $past(status))
    else $error("status read does not show detector state");
  a_line_select: assert property (
    src_ctrl_q[sync_pll_pkg::SRC_LINE_OVR] ##1
    src_ctrl_q[sync_pll_pkg::SRC_LINE_OVR] |-> o_line_ref_auto_select ==
    $past(src_ctrl_q[sync_pll_pkg::SRC_LINE_VAL]))
    else $error("line reference override not obeyed");
  a_line_auto: assert property (
    !src_ctrl_q[sync_pll_pkg::SRC_LINE_OVR] &&
    !active_q[sync_pll_pkg::DET_LINE] && active_q[sync_pll_pkg::DET_GREEN]
    |=> o_line_ref_auto_select)
    else $error("green sync not chosen when only it is active");
  a_frame_auto: assert property (
    !src_ctrl_q[sync_pll_pkg::SRC_FRAME_OVR] &&
    active_q[sync_pll_pkg::DET_FRAME_IN] |=> !o_frame_src_auto_select)
    else $error("frame input not chosen while active");
  a_ref_polarity: assert property (
    !line_sel_q |=> o_pll_ref == ($past(pin_sync_q[sync_pll_pkg::DET_LINE]) ^
    ~$past(pol_q[sync_pll_pkg::DET_LINE])))
    else $error("reference polarity not corrected");
  a_sep_filter: assert property (
    $changed(sep_out_q) |-> $past(tick) &&
    $past(loop_filter_node_cnt_q) >= $past(sep_ticks_q))
    else $error("separator passed a short pulse");
  a_tick_period: assert property (tick |-> ##1 !tick [*4])
    else $error("separator tick too frequent");
  a_divide_period: assert property (
    o_pll_feedback && !div_changed_q |-> gap_q == {1'b0, eff_div})
    else $error("feedback period is not setting plus one");
  a_div_reset: assert property (
    $rose(i_rst_n) |-> div_setting_q == sync_pll_pkg::DIV_RESET)
    else $error("divider setting not at reset value");
  a_pump_write: assert property (
    i_wr && i_addr == sync_pll_pkg::ADDR_VCO_PUMP |=> o_pump_current ==
    $past(i_wdata[5:3]) && o_vco_range == $past(i_wdata[7:6]))
    else $error("pump or range field not applied");
  a_coast_src: assert property (
    sep_ctrl_q[sync_pll_pkg::SEP_COAST_SEL] |=>
    o_coast_sync == $past(sep_out_q))
    else $error("coast does not follow separator");

  c_line_active: cover property ($rose(active_q[sync_pll_pkg::DET_LINE]));
  c_frame_sep: cover property ($rose(o_frame_src_auto_select));
  c_sep_change: cover property ($changed(sep_out_q));
  c_feedback: cover property (o_pll_feedback && !div_changed_q);
endmodule

// *** tb/sync_source_model.sv ***
// Video source model driving line, frame and green sync lines.
`timescale 1ns/1ps
module sync_source_model (
  // Clock.
  input wire logic i_clock,
  // Controls.
  input wire logic i_line_en,
  input wire logic i_line_pos,
  input wire logic i_frame_en,
  input wire logic i_green_en,
  input wire logic i_man_en,
  input wire logic i_man_level,
  // Sync lines.
  output logic o_line_sync,
  output logic o_frame_sync,
  output logic o_green_sync
);
  logic [9:0] cnt_q;
  logic line_pulse;
  assign line_pulse = i_line_en && (cnt_q[5:0] < 6'h08);
  initial begin
    cnt_q = 10'h000;
    o_line_sync = 1'b0;
    o_frame_sync = 1'b0;
    o_green_sync = 1'b1;
  end
  // Lines are 64 cycles with an 8 cycle pulse; frames are 1024 cycles.
  // An absent source sits at its idle level and never toggles.
  always @(posedge i_clock) begin
    cnt_q <= cnt_q + 10'h001;
    if (i_man_en) begin
      o_line_sync <= i_man_level;
    end else begin
      o_line_sync <= line_pulse ? i_line_pos : !i_line_pos;
    end
    o_frame_sync <= i_frame_en && (cnt_q < 10'h020);
    o_green_sync <= !(i_green_en && (cnt_q[5:0] < 6'h08));
  end
endmodule

// *** tb/video_sync_processing_pll_control_tb_top.sv ***
// Testbench for the sync processing and PLL control block.
`timescale 1ns/1ps
module video_sync_processing_pll_control_tb_top;
  localparam int WIN = 64 * 20;
  logic i_clock;
  logic i_rst_n;
  logic [sync_pll_pkg::ADDR_W-1:0] i_addr;
  logic [sync_pll_pkg::DATA_W-1:0] i_wdata;
  logic i_wr;
  logic i_rd;
  logic [sync_pll_pkg::DATA_W-1:0] o_rdata;
  logic line_s;
  logic frame_s;
  logic green_s;
  logic o_pll_ref;
  logic o_line_ref_auto_select;
  logic o_frame_src_auto_select;
  logic o_frame_sync_out;
  logic o_coast_sync;
  logic o_pll_feedback;
  logic [1:0] o_vco_range;
  logic [2:0] o_pump_current;
  logic line_en;
  logic line_pos;
  logic frame_en;
  logic green_en;
  logic man_en;
  logic man_level;
  int err_total;
  int cmp_count;

  sync_pll_ctrl #(.ACT_TIMEOUT_TICKS(64)) u_sync_pll_ctrl (
    .i_clock(i_clock), .i_rst_n(i_rst_n), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_line_sync(line_s), .i_frame_sync(frame_s),
    .i_green_embedded_sync_in(green_s), .o_pll_ref(o_pll_ref),
    .o_line_ref_auto_select(o_line_ref_auto_select),
    .o_frame_src_auto_select(o_frame_src_auto_select),
    .o_frame_sync_out(o_frame_sync_out), .o_coast_sync(o_coast_sync),
    .o_pll_feedback(o_pll_feedback), .o_vco_range(o_vco_range),
    .o_pump_current(o_pump_current));

  sync_source_model u_sync_source_model (
    .i_clock(i_clock), .i_line_en(line_en), .i_line_pos(line_pos),
    .i_frame_en(frame_en), .i_green_en(green_en), .i_man_en(man_en),
    .i_man_level(man_level), .o_line_sync(line_s),
    .o_frame_sync(frame_s), .o_green_sync(green_s));

  initial begin
    i_clock = 1'b0;
    forever #5 i_clock = ~i_clock;
  end

  task automatic give_verdict();
    $display("Mismatches %0d, compares %0d", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic tick();
    @(posedge i_clock);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clock);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clock);
    i_wr <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_clock);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clock);
    i_rd <= 1'b0;
    #1;
    d = o_rdata;
  endtask

  task automatic t_reset_regs();
    logic [7:0] a [7] = '{8'h01, 8'h02, 8'h03, 8'h0e, 8'h16, 8'h17, 8'h40};
    logic [7:0] e [7] = '{8'h69, 8'hd0, 8'h00, 8'h00, 8'h00, 8'h20, 8'h00};
    logic [7:0] d;
    for (int i = 0; i < 7; i++) begin
      rd(a[i], d);
      chk(d, e[i]);
    end
    wr(8'h14, 8'hff);
    rd(8'h14, d);
    chk(d, 8'h00);
  endtask

  task automatic measure(input int exp);
    int n;
    n = 0;
    do begin tick(); n++; end while (o_pll_feedback !== 1'b1 && n < 5000);
    n = 0;
    do begin tick(); n++; end while (o_pll_feedback !== 1'b1 && n < 5000);
    chk(n, exp);
  endtask

  task automatic t_div(input logic [11:0] s, input int exp);
    logic [7:0] d;
    wr(8'h01, s[11:4]);
    wr(8'h02, {s[3:0], 4'hf});
    rd(8'h02, d);
    chk(d, {s[3:0], 4'h0});
    repeat (2 * exp + 4) tick();
    measure(exp);
  endtask

  task automatic t_vco_pump();
    logic [7:0] d;
    for (int i = 0; i < 8; i++) begin
      wr(8'h03, {i[1:0], i[2:0], 3'b000});
      chk(o_vco_range, i[1:0]);
      chk(o_pump_current, i[2:0]);
      rd(8'h03, d);
      chk(d, {i[1:0], i[2:0], 3'b000});
    end
  endtask

  task automatic t_pol(input logic pos);
    logic [7:0] d;
    int hr;
    int hf;
    int hc;
    @(posedge i_clock);
    line_en <= 1'b1;
    line_pos <= pos;
    frame_en <= 1'b1;
    repeat (3 * WIN) tick();
    rd(8'h14, d);
    chk(d & 8'hb4, {2'b10, pos, 5'b10100});
    hr = 0;
    hf = 0;
    hc = 0;
    repeat (1024) begin
      tick();
      hr += int'(o_pll_ref === 1'b1);
      hf += int'(o_frame_sync_out === 1'b1);
      hc += int'(o_coast_sync === 1'b1);
    end
    chk(hr, 128);
    chk(hf, 32);
    chk(hc, 32);
  endtask

  task automatic t_sel(input logic [2:0] lfg, input logic [7:0] src,
                       input logic [1:0] sel);
    logic [7:0] d;
    logic [7:0] e;
    int hr;
    @(posedge i_clock);
    line_en <= lfg[2];
    line_pos <= 1'b1;
    frame_en <= lfg[1];
    green_en <= lfg[0];
    wr(8'h0e, src);
    repeat (3 * WIN) tick();
    rd(8'h14, d);
    e = {lfg[2], 2'b00, lfg[1], 2'b00, lfg[0], 1'b0};
    chk(d & 8'h92, e);
    chk(o_line_ref_auto_select, sel[1]);
    chk(o_frame_src_auto_select, sel[0]);
    // A live source gives 8 of every 64 cycles high once corrected.
    hr = 0;
    repeat (1024) begin
      tick();
      hr += int'(o_pll_ref === 1'b1);
    end
    chk(hr, (sel[1] ? lfg[0] : lfg[2]) ? 128 : 0);
  endtask

  task automatic t_sep();
    int hi;
    @(posedge i_clock);
    line_en <= 1'b0;
    frame_en <= 1'b0;
    green_en <= 1'b0;
    man_en <= 1'b1;
    man_level <= 1'b0;
    wr(8'h17, 8'h02);
    wr(8'h16, 8'h02);
    wr(8'h0e, 8'h03);
    repeat (200) tick();
    chk(o_frame_sync_out, 1'b0);
    @(posedge i_clock);
    man_level <= 1'b1;
    repeat (30) @(posedge i_clock);
    man_level <= 1'b0;
    hi = 0;
    repeat (200) begin
      tick();
      hi += int'(o_frame_sync_out === 1'b1);
    end
    chk(hi, 0);
    @(posedge i_clock);
    man_level <= 1'b1;
    repeat (120) tick();
    chk(o_frame_sync_out, 1'b1);
    chk(o_coast_sync, 1'b1);
    @(posedge i_clock);
    man_level <= 1'b0;
    repeat (120) tick();
    chk(o_frame_sync_out, 1'b0);
    wr(8'h16, 8'h03);
    repeat (120) tick();
    chk(o_frame_sync_out, 1'b1);
  endtask

  initial begin
    #950_000;
    err_total++;
    give_verdict();
  end

  initial begin
    i_rst_n = 1'b0;
    i_addr = 8'h00;
    i_wdata = 8'h00;
    i_wr = 1'b0;
    i_rd = 1'b0;
    line_en = 1'b0;
    line_pos = 1'b1;
    frame_en = 1'b0;
    green_en = 1'b0;
    man_en = 1'b0;
    man_level = 1'b0;
    err_total = 0;
    cmp_count = 0;
    repeat (20) @(posedge i_clock);
    i_rst_n <= 1'b1;
    t_reset_regs();
    measure(1694);
    t_vco_pump();
    t_div(12'hfff, 4096);
    t_div(12'h41f, 1056);
    t_div(12'h010, 17);
    t_div(12'h00f, 17);
    t_pol(1'b1);
    t_pol(1'b0);
    t_sel(3'b001, 8'h00, 2'b11);
    t_sel(3'b100, 8'h09, 2'b01);
    t_sel(3'b111, 8'h08, 2'b10);
    t_sel(3'b101, 8'h01, 2'b01);
    t_sel(3'b000, 8'h00, 2'b00);
    t_sel(3'b011, 8'h1a, 2'b10);
    t_sel(3'b110, 8'h1b, 2'b11);
    t_sel(3'b010, 8'h01, 2'b00);
    t_sep();
    give_verdict();
  end
endmodule
